// >>> hw/nfa_lamp_flasher.sv
// fault lamp flasher: toggles while an error is pending
`timescale 1ns/100ps
module nfa_lamp_flasher
	import nfa_pkg::*;
#(
	parameter int HALF_CYC = LAMP_HALF_CYC
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rstSync_n,
	// control
	input  wire logic flashEn,
	// lamp
	output logic      lampOn
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        lamp;
	} nfa_flash_t;
	nfa_flash_t s_r, s_nxt;

	// half-period counter, lamp off when idle
	always_comb begin
		s_nxt = s_r;
		if (!flashEn) begin
			s_nxt.cnt  = '0;
			s_nxt.lamp = 1'b0;
		end else if (s_r.cnt >= 32'(HALF_CYC - 1)) begin
			s_nxt.cnt  = '0;
			s_nxt.lamp = ~s_r.lamp;
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lampOn = s_r.lamp;
endmodule

// >>> hw/nfa_nonfatal_alarm_unit.sv
// non-fatal alarm unit: raises user and system non-fatal errors and clears the user ones
// Behaviour
// RULE1 - number zero clears, 1..511 raises
// RULE2 - number equal to system word: system error
// RULE3 - clear by number, all, or most serious
// RULE4 - user error sets alarm flag, keeps running
// RULE5 - user error sets its per-number flag bit
// RULE6 - user code word is 0x4100 plus number
// RULE7 - more serious concurrent error code wins
// RULE8 - raised error appends code and time to log
// RULE9 - raised error flashes fault lamp
// RULE10 - word source registers up to 16 chars
// RULE11 - message follows later source word changes
// RULE12 - system error: code, log, details, flags, lamp
// RULE13 - system error leaves per-number flags alone
// RULE14 - code 008B details: bit15 conflict, unit
// RULE15 - codes 0200/0300 details carry unit number
// RULE16 - setup bit suppresses user error logging
// RULE17 - suppressed user error still sets flags, code
// RULE18 - system errors always logged
// RULE19 - executor issues per scan or rising edge
// RULE20 - system error not cleared by clear op
// RULE21 - error flag when number exceeds 511
// RULE22 - most serious clear takes smallest number
// RULE23 - alarm flag drops when no bit remains
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module nfa_nonfatal_alarm_unit
	import nfa_pkg::*;
#(
	parameter int NUM_BITS = 512
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// alarm operation from the executor
	input  wire logic        opValid,
	input  wire logic [15:0] alarmNum,
	input  wire logic [15:0] srcValue,
	input  wire logic [15:0] srcNext,
	input  wire logic        srcIsWord,
	input  wire logic [15:0] srcAddr,
	input  wire logic        fatalCoincident,
	input  wire logic [15:0] fatalCode,
	input  wire logic [31:0] timeStamp,
	// error log write port
	output logic             logWrite,
	output logic [15:0]      logCode,
	output logic [31:0]      logTime,
	// message registration
	output logic             msgValid,
	output logic [15:0]      msgAddr,
	// status outputs
	output logic             instrErr,
	output logic             alarmFlag,
	output logic [15:0]      errorCode,
	output logic [15:0]      sysDetails,
	output logic             faultLamp,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);
	logic rstSync_n;
	logic [1:0] rstPipe_r;

	// reset release synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe_r <= 2'b00;
		end else begin
			rstPipe_r <= {rstPipe_r[0], 1'b1};
		end
	end
	assign rstSync_n = rstPipe_r[1];

	typedef struct packed {
		logic [NUM_BITS-1:0] flags;
		logic [15:0]         code;
		logic [15:0]         sysNum;
		logic [15:0]         details;
		logic                sysPending;
		logic                sysFlag;
		logic [15:0]         setup;
		logic [15:0]         logCount;
		logic [15:0]         flagSel;
		logic                instrErr;
		logic                logWr;
		logic [15:0]         logCode;
		logic [31:0]         logTime;
		logic                msgValid;
		logic [15:0]         msgAddr;
		logic [31:0]         rdata;
		logic                ack;
	} nfa_state_reg_t;
	nfa_state_reg_t s_r, s_nxt;

	logic [8:0]  lowIdx;
	logic        anyFlag;
	logic [15:0] userCode;
	logic        isClear;
	logic        inRange;
	logic        isSystem;
	logic        busReq;
	logic [15:0] detailsFix;

	// lowest set per-number bit, for most-serious clear
	always_comb begin
		lowIdx = '0;
		for (int i = NUM_BITS - 1; i >= 1; i--) begin
			if (s_r.flags[i]) begin
				lowIdx = 9'(i); // RULE22
			end
		end
	end

	// decode of the incoming alarm operation
	assign anyFlag  = |s_r.flags;
	assign isClear  = (alarmNum == NUM_CLEAR); // RULE1
	assign inRange  = (alarmNum <= NUM_MAX); // RULE21
	assign isSystem = !isClear && inRange && (alarmNum == s_r.sysNum); // RULE2
	assign userCode = USER_CODE_BASE + alarmNum; // RULE6
	assign busReq   = (avs_read || avs_write) && !s_r.ack;

	// details word shaped per system code
	always_comb begin
		detailsFix = srcNext;
		case (srcValue)
			SYS_IRQ_CODE: detailsFix = srcNext; // RULE14
			SYS_BUS_CODE: detailsFix = (srcNext > BUS_UNIT_MAX) ? BUS_UNIT_MAX : srcNext; // RULE15
			SYS_SIO_CODE: detailsFix = (srcNext > SIO_UNIT_MAX) ? SIO_UNIT_UNK : srcNext; // RULE15
			default:      detailsFix = srcNext;
		endcase
	end

	// operation and bus next-state
	always_comb begin
		s_nxt = s_r;
		s_nxt.logWr    = 1'b0;
		s_nxt.msgValid = s_r.msgValid;
		s_nxt.ack      = 1'b0;
		if (opValid) begin // RULE19
			s_nxt.instrErr = !inRange; // RULE21
			if (!inRange) begin
				// out-of-range number does nothing else
			end else if (isClear) begin
				if (srcValue >= 16'h0001 && srcValue <= NUM_MAX) begin
					s_nxt.flags[srcValue[8:0]] = 1'b0; // RULE3
				end else if (srcValue == SRC_CLR_ALL) begin
					s_nxt.flags = '0; // RULE3
				end else if (anyFlag) begin
					s_nxt.flags[lowIdx] = 1'b0; // RULE3 RULE22
				end
				// system error survives every clear op
				s_nxt.sysPending = s_r.sysPending; // RULE20
				s_nxt.msgValid   = 1'b0;
				if (!s_r.sysPending) begin
					s_nxt.code = RESET_WORD;
				end
			end else if (isSystem) begin
				// flags untouched, no user code written
				s_nxt.code       = fatalCoincident ? fatalCode : srcValue; // RULE12 RULE13 RULE7
				s_nxt.details    = detailsFix; // RULE12
				s_nxt.sysPending = 1'b1; // RULE12
				s_nxt.sysFlag    = 1'b1; // RULE12
				s_nxt.logWr      = 1'b1; // RULE18 RULE8
				s_nxt.logCode    = srcValue;
				s_nxt.logTime    = timeStamp;
			end else begin
				s_nxt.flags[alarmNum[8:0]] = 1'b1; // RULE5 RULE17
				if (fatalCoincident || s_r.code > userCode) begin
					s_nxt.code = fatalCoincident ? fatalCode : s_r.code; // RULE7
				end else begin
					s_nxt.code = userCode; // RULE6 RULE17
				end
				s_nxt.logWr   = !s_r.setup[CTRL_LOGOFF_BIT]; // RULE16 RULE8
				s_nxt.logCode = userCode;
				s_nxt.logTime = timeStamp;
				// only a word source names a message
				s_nxt.msgValid = srcIsWord; // RULE10 RULE11
				s_nxt.msgAddr  = srcAddr; // RULE10 RULE11
			end
		end
		if (s_r.logWr) begin
			s_nxt.logCount = s_r.logCount + 16'h1;
		end
		// write lands at the edge where waitrequest is seen low
		if (avs_write && s_r.ack) begin
			case (avs_address)
				REG_CTRL: begin
					if (avs_byteenable[0]) s_nxt.setup[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1]) s_nxt.setup[15:8] = avs_writedata[15:8];
				end
				REG_SYSNUM: begin
					if (avs_byteenable[0]) s_nxt.sysNum[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1]) s_nxt.sysNum[15:8] = avs_writedata[15:8];
				end
				REG_FLAGSEL: begin
					if (avs_byteenable[0]) s_nxt.flagSel[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1]) s_nxt.flagSel[15:8] = avs_writedata[15:8];
				end
				default: begin
				end
			endcase
		end
		// avalon access, answered one cycle after request
		if (busReq) begin
			s_nxt.ack   = 1'b1;
			s_nxt.rdata = UNMAPPED_DATA;
			if (!avs_write) begin
				case (avs_address)
					REG_CTRL:     s_nxt.rdata = {16'h0, s_r.setup};
					REG_STATUS:   s_nxt.rdata = {16'h0, anyFlag, 7'h0, s_r.sysFlag,
						6'h0, s_r.instrErr};
					REG_CODE:     s_nxt.rdata = {16'h0, s_r.code};
					REG_SYSNUM:   s_nxt.rdata = {16'h0, s_r.sysNum};
					REG_DETAIL:   s_nxt.rdata = {16'h0, s_r.details};
					REG_LOGCNT:   s_nxt.rdata = {16'h0, s_r.logCount};
					REG_MSGADR:   s_nxt.rdata = {15'h0, s_r.msgValid, s_r.msgAddr};
					REG_FLAGSEL:  s_nxt.rdata = {16'h0, s_r.flagSel};
					REG_FLAGWORD: s_nxt.rdata = {16'h0,
						s_r.flags[{s_r.flagSel[4:0], 4'h0} +: 16]};
					REG_LASTCODE: s_nxt.rdata = {16'h0, s_r.logCode};
					default:      s_nxt.rdata = UNMAPPED_DATA;
				endcase
			end
		end
		s_nxt.flags[0] = 1'b0;
	end

	// state register, cleared at power-up
	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			s_r        <= '0;
			s_r.sysNum <= RESET_SYSNUM;
		end else begin
			s_r <= s_nxt;
		end
	end

	// lamp flashes while any non-fatal error stands
	nfa_lamp_flasher #(
		.HALF_CYC (LAMP_HALF_CYC)
	) u_lamp (
		.core_clk  (core_clk),
		.rstSync_n (rstSync_n),
		.flashEn   (anyFlag || s_r.sysPending), // RULE9 RULE12
		.lampOn    (faultLamp)
	);

	// outputs
	assign alarmFlag       = anyFlag; // RULE4 RULE23
	assign errorCode       = s_r.code;
	assign sysDetails      = s_r.details;
	assign instrErr        = s_r.instrErr;
	assign logWrite        = s_r.logWr;
	assign logCode         = s_r.logCode;
	assign logTime         = s_r.logTime;
	assign msgValid        = s_r.msgValid;
	assign msgAddr         = s_r.msgAddr;
	assign avs_readdata    = s_r.rdata;
	assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
endmodule

// >>> pkg/nfa_pkg.sv
// constants and types shared by the non-fatal alarm unit
package nfa_pkg;
	// avalon register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_CODE      = 8'h08;
	localparam logic [7:0] REG_SYSNUM    = 8'h0C;
	localparam logic [7:0] REG_DETAIL    = 8'h10;
	localparam logic [7:0] REG_LOGCNT    = 8'h14;
	localparam logic [7:0] REG_MSGADR    = 8'h18;
	localparam logic [7:0] REG_FLAGSEL   = 8'h1C;
	localparam logic [7:0] REG_FLAGWORD  = 8'h20;
	localparam logic [7:0] REG_LASTCODE  = 8'h24;
	// field positions
	localparam int CTRL_LOGOFF_BIT   = 15;
	localparam int STAT_ALARM_BIT    = 15;
	localparam int STAT_SYSERR_BIT   = 7;
	localparam int STAT_INSTERR_BIT  = 0;
	localparam int REFRESH_BIT       = 15;
	// numbers and codes
	localparam logic [15:0] NUM_CLEAR     = 16'h0000;
	localparam logic [15:0] NUM_MAX       = 16'h01FF;
	localparam logic [15:0] SRC_CLR_ALL   = 16'hFFFF;
	localparam logic [15:0] USER_CODE_BASE = 16'h4100;
	localparam logic [15:0] SYS_IRQ_CODE  = 16'h008B;
	localparam logic [15:0] SYS_BUS_CODE  = 16'h0200;
	localparam logic [15:0] SYS_SIO_CODE  = 16'h0300;
	localparam logic [15:0] BUS_UNIT_MAX  = 16'h000F;
	localparam logic [15:0] SIO_UNIT_MAX  = 16'h005F;
	localparam logic [15:0] SIO_UNIT_UNK  = 16'h00FF;
	localparam logic [15:0] RESET_SYSNUM  = 16'h0000;
	localparam logic [15:0] RESET_WORD    = 16'h0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// lamp flash half period
	localparam int LAMP_HALF_NS  = 500_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int LAMP_HALF_CYC = LAMP_HALF_NS / CLK_PERIOD_NS;
	localparam int MSG_WORDS     = 8;
	localparam int NUM_FLAG_WORDS = 32;
	typedef enum logic [1:0] {NFA_IDLE, NFA_CLEAR, NFA_DONE} nfa_state_t;
endpackage

// >>> tb/nfa_exec_model.sv
// executor model presenting alarm operations
`timescale 1ns/100ps
module nfa_exec_model
	import nfa_pkg::*;
(
	// clock
	input wire logic   core_clk,
	// alarm operation
	output logic       opValid,
	output logic [15:0] alarmNum,
	output logic [15:0] srcValue,
	output logic [15:0] srcNext,
	output logic       srcIsWord,
	output logic [15:0] srcAddr,
	output logic       fatalCoincident,
	output logic [31:0] timeStamp
);
	// idle operands at time zero
	initial begin
		{opValid, srcIsWord, fatalCoincident} = 3'b000;
		{alarmNum, srcValue, srcNext, srcAddr} = '0;
		timeStamp = 32'h0;
	end
	// time of occurrence
	always @(posedge core_clk) timeStamp <= timeStamp + 32'h1;
	// one operation, repeated each scan when reps is above one
	task automatic issue(input logic [15:0] num, s, nx, input logic w, fc, input int reps);
		@(posedge core_clk);
		opValid <= 1'b1;
		{alarmNum, srcValue, srcNext, srcAddr} <= {num, s, nx, s};
		srcIsWord <= w;
		fatalCoincident <= fc;
		repeat (reps) @(posedge core_clk);
		// stale operands shown inverted
		opValid <= 1'b0;
		{alarmNum, srcValue, srcNext, srcAddr} <= ~{num, s, nx, s};
		fatalCoincident <= 1'b0;
	endtask
endmodule

// >>> tb/nfa_nonfatal_alarm_unit_tb_top.sv
// self-checking bench for the non-fatal alarm unit
`timescale 1ns/100ps
module nfa_nonfatal_alarm_unit_tb_top
	import nfa_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        opValid, srcIsWord, fatalCoincident, logWrite, msgValid, instrErr;
	logic        alarmFlag, faultLamp, avs_read, avs_write, avs_waitrequest;
	logic [15:0] alarmNum, srcValue, srcNext, srcAddr, logCode, msgAddr, errorCode, sysDetails;
	logic [31:0] timeStamp, logTime, avs_writedata, avs_readdata, rd;
	logic [7:0]  avs_address;
	logic [15:0] codes [3] = '{SYS_IRQ_CODE, SYS_SIO_CODE, SYS_BUS_CODE};
	logic [15:0] dets [3] = '{16'h8003, SIO_UNIT_UNK, BUS_UNIT_MAX};
	int          fails = 0;
	int          numChecks = 0;
	int          n;
	// 10 MHz scan clock
	always #50 core_clk = ~core_clk;
	// unit and executor
	nfa_nonfatal_alarm_unit i_dut (.core_clk, .rst_n, .opValid, .alarmNum, .srcValue, .srcNext,
		.srcIsWord, .srcAddr, .fatalCoincident, .fatalCode(16'h8000), .timeStamp, .logWrite,
		.logCode, .logTime, .msgValid, .msgAddr, .instrErr, .alarmFlag, .errorCode, .sysDetails,
		.faultLamp, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
		.avs_readdata, .avs_waitrequest);
	nfa_exec_model i_exec (.core_clk, .opValid, .alarmNum, .srcValue, .srcNext, .srcIsWord,
		.srcAddr, .fatalCoincident, .timeStamp);
	// compare one value
	task automatic chk(input string what, input logic [31:0] seen, exp);
		numChecks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// avalon access held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{avs_address, avs_writedata} <= {a, d};
		{avs_write, avs_read} <= {wr, !wr};
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		{avs_write, avs_read} <= 2'b00;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	// one alarm operation, results looked at mid-cycle
	task automatic op(input logic [15:0] num, s, nx = 16'h0, input logic w = 1'b0,
		fc = 1'b0, input int reps = 1);
		i_exec.issue(num, s, nx, w, fc, reps);
		@(negedge core_clk);
	endtask
	task automatic print_verdict;
		if (fails == 0 && numChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		print_verdict();
	end
	// main sequence
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rdc("sysnum", REG_SYSNUM, 32'h0);
		rdc("setup", REG_CTRL, 32'h0);
		bus(1'b1, 8'h3C, 32'hFFFF);
		rdc("unmapped", 8'h3C, UNMAPPED_DATA);
		// user errors: message source, top number, lowest number
		op(16'h001F, 16'h0100, 16'h0, 1'b1);
		chk("code", {alarmFlag, instrErr, errorCode}, 18'h2411F);
		chk("log", {logWrite, logCode}, 17'h1411F);
		chk("msg", {msgValid, msgAddr}, 17'h10100);
		chk("time", logTime, timeStamp - 32'h1);
		op(NUM_MAX, 16'h0);
		chk("top", errorCode, 16'h42FF);
		op(16'h0001, 16'h0);
		bus(1'b1, REG_FLAGSEL, 32'h1);
		rdc("word1", REG_FLAGWORD, 32'h8000);
		bus(1'b1, REG_FLAGSEL, 32'h1F);
		rdc("word31", REG_FLAGWORD, 32'h8000);
		n = 0;
		while (faultLamp !== 1'b1 && n < 5100) begin
			@(negedge core_clk);
			n++;
		end
		chk("lamp", faultLamp, 1'b1);
		// clear by number, most serious, then everything
		op(NUM_CLEAR, NUM_MAX);
		rdc("word31", REG_FLAGWORD, 32'h0);
		op(NUM_CLEAR, 16'h0200);
		bus(1'b1, REG_FLAGSEL, 32'h0);
		rdc("word0", REG_FLAGWORD, 32'h0);
		chk("left", alarmFlag, 1'b1);
		op(NUM_CLEAR, SRC_CLR_ALL);
		chk("all", {alarmFlag, errorCode}, 17'h0);
		repeat (2) @(negedge core_clk);
		chk("dark", faultLamp, 1'b0);
		// out of range, coincident serious error, log off every scan
		op(16'h0200, 16'h0);
		chk("refused", {instrErr, alarmFlag, logWrite}, 3'b100);
		op(16'h0005, 16'h0, 16'h0, 1'b0, 1'b1);
		chk("serious", errorCode, 16'h8000);
		bus(1'b1, REG_CTRL, 32'h8000);
		op(16'h0007, 16'h0, 16'h0, 1'b0, 1'b0, 3);
		chk("quiet", {logWrite, alarmFlag}, 2'b01);
		op(NUM_CLEAR, SRC_CLR_ALL);
		// system errors through the dummy number, logged with log off
		bus(1'b1, REG_SYSNUM, 32'h000A);
		for (int i = 0; i < 3; i++) begin
			op(16'h000A, codes[i], dets[i]);
			chk("syslog", {logWrite, logCode}, {1'b1, codes[i]});
			chk("details", sysDetails, dets[i]);
			chk("noflag", alarmFlag, 1'b0);
		end
		rdc("status", REG_STATUS, 32'h0080);
		// an ordinary clear leaves the system error standing
		op(NUM_CLEAR, SRC_CLR_ALL);
		chk("keptcode", errorCode, SYS_BUS_CODE);
		rdc("sysheld", REG_STATUS, 32'h0080);
		rdc("logcnt", REG_LOGCNT, 32'h7);
		print_verdict();
	end
endmodule

// >>> tb/nfa_unit_monitor.sv
// port checker for the non-fatal alarm unit
`timescale 1ns/100ps
module nfa_unit_monitor
	import nfa_pkg::*;
(
	// clock, reset and alarm operation
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        opValid,
	input wire logic [15:0] alarmNum,
	input wire logic [15:0] srcValue,
	input wire logic        fatalCoincident,
	input wire logic [15:0] fatalCode,
	// results and register writes
	input wire logic        logWrite,
	input wire logic [15:0] logCode,
	input wire logic        instrErr,
	input wire logic        alarmFlag,
	input wire logic [15:0] errorCode,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest
);
	logic [15:0] sysNum_r;
	logic        logOff_r;
	logic        wrOk, raise, userOp, sysOp;
	// shadow copies of system number and setup bit
	assign wrOk = avs_write && !avs_waitrequest;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysNum_r <= RESET_SYSNUM;
			logOff_r <= 1'b0;
		end else if (wrOk && avs_address == REG_SYSNUM) begin
			sysNum_r <= avs_writedata[15:0];
		end else if (wrOk && avs_address == REG_CTRL) begin
			logOff_r <= avs_writedata[CTRL_LOGOFF_BIT];
		end
	end
	// kind of operation presented
	assign raise = opValid && alarmNum != NUM_CLEAR && alarmNum <= NUM_MAX;
	assign userOp = raise && alarmNum != sysNum_r;
	assign sysOp = raise && alarmNum == sysNum_r;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_userLog;
		logWrite && logCode == USER_CODE_BASE + $past(alarmNum);
	endsequence
	sequence s_sysLog;
		logWrite && logCode == $past(srcValue) && $stable(alarmFlag);
	endsequence
	AST_INSTR_ERR: assert property (opValid |=> instrErr == ($past(alarmNum) > NUM_MAX))
		else $error("instruction error flag wrong");
	AST_REFUSED: assert property (opValid && alarmNum > NUM_MAX |=> !logWrite)
		else $error("refused number was logged");
	AST_USER_RAISE: assert property (userOp |=>
		alarmFlag && errorCode >= USER_CODE_BASE + $past(alarmNum))
		else $error("user error not raised");
	AST_USER_LOG: assert property (userOp && !logOff_r && !fatalCoincident |=> s_userLog)
		else $error("user error not logged");
	AST_LOG_OFF: assert property (userOp && logOff_r |=> !logWrite && alarmFlag)
		else $error("suppressed user error wrong");
	AST_SYS: assert property (sysOp |=> s_sysLog)
		else $error("system error wrong");
	AST_FATAL: assert property (userOp && fatalCoincident && errorCode <= fatalCode
		&& fatalCode > USER_CODE_BASE + alarmNum |=> errorCode == $past(fatalCode))
		else $error("serious code lost");
	AST_CLR_ALL: assert property (opValid && alarmNum == NUM_CLEAR
		&& srcValue == SRC_CLR_ALL |=> !alarmFlag)
		else $error("clear all left a flag");
endmodule
bind nfa_nonfatal_alarm_unit nfa_unit_monitor i_mon (.core_clk, .rst_n, .opValid, .alarmNum,
	.srcValue, .fatalCoincident, .fatalCode, .logWrite, .logCode, .instrErr, .alarmFlag,
	.errorCode, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest);
